// >>> hdl/sdrx_front.sv
// Front-end control: modes, input mux, loop-through, host registers, FIFO
// Function
// - Master mode: device auto-detects and processes streams
// - Slave mode reclocks non-standard streams too
// - Features on after reset, individually host-disabled
// - Select high routes input one
// - Select low routes input two
// - Loop output buffered or reclocked by selection
// - Loop output mutes on lost signal; tristates
// - Loop slew follows HD or SD rate
// - Accept 1.485, 1.485/1.001 Gb/s, 270 Mb/s
// - Status map is read-only to host
// - Carrier-valid muxed by same select, to lock
`timescale 1ns/1ns

module sdrx_fifo #(
	parameter int unsigned WIDTH = 20,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic      [WIDTH-1:0] o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} sdrx_fifo_st_t;
	sdrx_fifo_st_t q, d;
	logic push, pop;

	assign o_in_ready  = (q.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (q.cnt != '0);
	assign o_out_data  = q.mem[q.rd];
	assign push = i_in_valid && o_in_ready;
	assign pop  = o_out_valid && i_out_ready;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wr] = i_in_data;
			d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
		end
		if (pop) begin
			d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
		end
		case ({push, pop})
			2'b10:   d.cnt = q.cnt + 1'b1;
			2'b01:   d.cnt = q.cnt - 1'b1;
			default: d.cnt = q.cnt;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// A full FIFO with a stalled reader must not move its write pointer
	a_fifo_no_overrun: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(!o_in_ready && i_in_valid && !i_out_ready) |=> $stable(q.wr))
		else $error("FIFO accepts data while full");
	a_fifo_count: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		q.cnt <= (AW+1)'(DEPTH))
		else $error("FIFO count beyond depth");
endmodule // sdrx_fifo

module sdrx_front (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Mode and input selection pins
	input  wire logic        i_mode_master,
	input  wire logic        i_input_choose,
	input  wire logic        i_serial_in_one,
	input  wire logic        i_serial_in_two,
	input  wire logic        i_carrier_valid_n_one,
	input  wire logic        i_carrier_valid_n_two,
	output logic             o_reclock_in,
	output logic             o_carrier_detect,
	output logic             o_auto_detect,
	output logic             o_pass_nonstandard,
	// From lock detect and reclocker
	input  wire logic        i_locked,
	input  wire logic        i_rate_hd,
	input  wire logic        i_rate_div1001,
	input  wire logic        i_reclocked_bit,
	output logic      [20:0] o_line_rate_kbps,
	// Loop-through driver
	input  wire logic        i_loop_enable,
	input  wire logic        i_reclock_sel_in,
	output logic             o_reclock_sel_out,
	output logic             o_reclock_sel_oe,
	output logic             o_loop_data,
	output logic             o_loop_oe,
	output logic             o_loop_hd_slew,
	// Processing features
	output logic      [15:0] o_feature_enable,
	// Status from the processing core
	input  wire logic [15:0] i_rx_err,
	input  wire logic [15:0] i_edh_err,
	input  wire logic [15:0] i_det_format,
	input  wire logic [15:0] i_payload_low,
	input  wire logic [15:0] i_payload_high,
	input  wire logic [15:0] i_raster_one,
	input  wire logic [15:0] i_raster_two,
	input  wire logic [15:0] i_raster_three,
	input  wire logic [15:0] i_raster_four,
	// Host serial port
	input  wire logic        i_host_sclk,
	input  wire logic        i_host_cs_n,
	input  wire logic        i_host_sdin,
	output logic             o_host_sdout,
	// Parallel word path
	input  wire logic [19:0] i_word_data,
	input  wire logic        i_word_valid,
	output logic             o_word_ready,
	output logic      [19:0] o_out_data,
	output logic             o_out_valid,
	input  wire logic        i_out_ready
);
	typedef struct packed {
		logic [1:0]           mode;
		logic [1:0]           choose;
		logic [1:0]           sin1;
		logic [1:0]           sin2;
		logic [1:0]           cvn1;
		logic [1:0]           cvn2;
		logic [1:0]           en;
		logic [1:0]           rsel;
		logic [2:0]           sclk;
		logic [1:0]           cs_n;
		logic [1:0]           sdi;
		sdrx_pkg::sdrx_hp_state_t st;
		logic [4:0]           cnt;
		logic [15:0]          shift;
		logic                 is_read;
		logic [11:0]          addr;
		logic [15:0]          disable_q;
		logic                 reclock_in;
		logic                 carrier;
		logic                 loop_data;
		logic                 loop_oe;
		logic                 slew;
		logic                 sel_out;
		logic [20:0]          rate;
	} sdrx_st_t;
	sdrx_st_t q, d;

	logic        master, choose, carrier_ok, use_reclocked, mute, rise;
	logic [15:0] cmd_word, rd_value;

	assign master     = q.mode[1];
	assign choose     = q.choose[1];
	assign rise       = q.sclk[1] && !q.sclk[2];
	assign cmd_word   = {q.shift[14:0], q.sdi[1]};
	// Carrier follows the same select as the data
	assign carrier_ok = choose ? !q.cvn1[1] : !q.cvn2[1];

	// Master mode drives the bypass pin from lock; slave mode reads it
	assign use_reclocked = master ? i_locked : q.rsel[1];
	assign mute = !carrier_ok || (use_reclocked && !i_locked);

	// Status registers are pure reads of live fields
	always_comb begin
		case (cmd_word[sdrx_pkg::HP_AW-1:0])
			sdrx_pkg::OFF_PROC_DISABLE: rd_value = q.disable_q;
			sdrx_pkg::OFF_RX_ERR:
				rd_value = i_rx_err & sdrx_pkg::MASK_RX_ERR;
			sdrx_pkg::OFF_EDH_ERR:
				rd_value = i_edh_err & sdrx_pkg::MASK_EDH_ERR;
			sdrx_pkg::OFF_DET_FORMAT:
				rd_value = i_det_format & sdrx_pkg::MASK_DET_FORMAT;
			sdrx_pkg::OFF_PAYLOAD_LOW:    rd_value = i_payload_low;
			sdrx_pkg::OFF_PAYLOAD_HIGH:   rd_value = i_payload_high;
			sdrx_pkg::OFF_RASTER_ONE:
				rd_value = i_raster_one & sdrx_pkg::MASK_RASTER_S;
			sdrx_pkg::OFF_RASTER_TWO:
				rd_value = i_raster_two & sdrx_pkg::MASK_RASTER_S;
			sdrx_pkg::OFF_RASTER_THREE:
				rd_value = i_raster_three & sdrx_pkg::MASK_RASTER_L;
			sdrx_pkg::OFF_RASTER_FOUR:
				rd_value = i_raster_four & sdrx_pkg::MASK_RASTER_L;
			default:                      rd_value = 16'h0000;
		endcase
	end

	always_comb begin
		d = q;
		// Pin synchronisers
		d.mode   = {q.mode[0], i_mode_master};
		d.choose = {q.choose[0], i_input_choose};
		d.sin1   = {q.sin1[0], i_serial_in_one};
		d.sin2   = {q.sin2[0], i_serial_in_two};
		d.cvn1   = {q.cvn1[0], i_carrier_valid_n_one};
		d.cvn2   = {q.cvn2[0], i_carrier_valid_n_two};
		d.en     = {q.en[0], i_loop_enable};
		d.rsel   = {q.rsel[0], i_reclock_sel_in};
		d.sclk   = {q.sclk[1:0], i_host_sclk};
		d.cs_n   = {q.cs_n[0], i_host_cs_n};
		d.sdi    = {q.sdi[0], i_host_sdin};
		// Input mux
		d.reclock_in = choose ? q.sin1[1] : q.sin2[1];
		d.carrier    = carrier_ok;
		// Loop-through
		d.loop_data = mute ? 1'b0 :
			(use_reclocked ? i_reclocked_bit : d.reclock_in);
		d.loop_oe   = q.en[1];
		d.slew      = i_rate_hd;
		d.sel_out   = master && i_locked;
		// Rate indication
		if (!i_rate_hd) begin
			d.rate = sdrx_pkg::RATE_SD_KBPS;
		end else if (i_rate_div1001) begin
			d.rate = sdrx_pkg::RATE_HDM_KBPS;
		end else begin
			d.rate = sdrx_pkg::RATE_HD_KBPS;
		end
		// Host port
		if (q.cs_n[1]) begin
			d.st = sdrx_pkg::HP_IDLE;
		end else begin
			case (q.st)
				sdrx_pkg::HP_IDLE: begin
					d.st  = sdrx_pkg::HP_CMD;
					d.cnt = '0;
				end
				sdrx_pkg::HP_CMD: if (rise) begin
					d.shift = cmd_word;
					d.cnt   = q.cnt + 5'h01;
					if (q.cnt == sdrx_pkg::HP_LAST) begin
						d.st      = sdrx_pkg::HP_DATA;
						d.cnt     = '0;
						d.is_read = cmd_word[sdrx_pkg::HP_RD_BIT];
						d.addr    = cmd_word[sdrx_pkg::HP_AW-1:0];
						if (cmd_word[sdrx_pkg::HP_RD_BIT]) begin
							d.shift = rd_value;
						end
					end
				end
				sdrx_pkg::HP_DATA: if (rise) begin
					d.shift = q.is_read ? {q.shift[14:0], 1'b0} : cmd_word;
					d.cnt   = q.cnt + 5'h01;
					if (q.cnt == sdrx_pkg::HP_LAST) begin
						d.st = sdrx_pkg::HP_DONE;
						// Only the disable word takes writes
						if (!q.is_read &&
							q.addr == sdrx_pkg::OFF_PROC_DISABLE) begin
							d.disable_q = cmd_word &
								sdrx_pkg::PROC_DISABLE_MASK;
						end
					end
				end
				sdrx_pkg::HP_DONE: d.st = sdrx_pkg::HP_DONE;
				default: d.st = sdrx_pkg::HP_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_reclock_in       = q.reclock_in;
	assign o_carrier_detect   = q.carrier;
	assign o_auto_detect      = master;
	// Slave mode locks to any stream; the pins decide the format
	assign o_pass_nonstandard = !master;
	assign o_line_rate_kbps   = q.rate;
	assign o_reclock_sel_out  = q.sel_out;
	assign o_reclock_sel_oe   = master;
	assign o_loop_data        = q.loop_data;
	assign o_loop_oe          = q.loop_oe;
	assign o_loop_hd_slew     = q.slew;
	assign o_feature_enable   = ~q.disable_q & sdrx_pkg::PROC_DISABLE_MASK;
	assign o_host_sdout       = q.is_read && (q.st == sdrx_pkg::HP_DATA) &&
		q.shift[15];

	sdrx_fifo #(
		.WIDTH (sdrx_pkg::WORD_W),
		.DEPTH (sdrx_pkg::FIFO_DEPTH)
	) sdrx_fifo_i (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_in_data   (i_word_data),
		.i_in_valid  (i_word_valid),
		.o_in_ready  (o_word_ready),
		.o_out_data  (o_out_data),
		.o_out_valid (o_out_valid),
		.i_out_ready (i_out_ready)
	);

	// Mode pin reaches the outputs through exactly two flip-flops
	a_mode_auto: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		($past(i_rst_n) && $past(i_rst_n, 2)) |->
		(o_auto_detect == $past(i_mode_master, 2)) &&
		(o_pass_nonstandard == !o_auto_detect))
		else $error("Auto detect and non-standard pass disagree");
	a_pick_one: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		choose |=> o_reclock_in == $past(q.sin1[1]))
		else $error("Input one not routed");
	a_pick_two: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		!choose |=> o_reclock_in == $past(q.sin2[1]))
		else $error("Input two not routed");
	a_carrier_mux: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(!choose && q.cvn2[1]) |=> !o_carrier_detect)
		else $error("Carrier not taken from input two");
	a_loop_mute: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		!carrier_ok |=> !o_loop_data)
		else $error("Loop output not muted on lost carrier");
	a_loop_hiz: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		!q.en[1] |=> !o_loop_oe)
		else $error("Loop driver not released");
	a_slew_rate: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(i_rate_hd) |=> o_loop_hd_slew &&
		(o_line_rate_kbps != sdrx_pkg::RATE_SD_KBPS))
		else $error("Slew or rate not following HD");
	a_loop_source: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(!mute && use_reclocked) |=>
		(o_loop_data == $past(i_reclocked_bit)))
		else $error("Reclocked loop source not used");
	a_status_ro: assert property (
		@(posedge i_clock) disable iff (!i_rst_n)
		(q.addr != sdrx_pkg::OFF_PROC_DISABLE) |=>
		$stable(q.disable_q))
		else $error("Status write changed control");
	a_feature_rst: assert property (
		@(posedge i_clock)
		$rose(i_rst_n) |->
		(o_feature_enable == sdrx_pkg::PROC_DISABLE_MASK))
		else $error("Features not enabled after reset");
endmodule // sdrx_front

// >>> hdl/sdrx_none.sv
// Spare design file; the block's logic sits in sdrx_front.sv

// >>> hdl/sdrx_pkg.sv
// Shared constants of the receiver front-end control block
package sdrx_pkg;
	// Clock
	localparam int unsigned CLOCK_HZ   = 20_000_000;
	localparam int unsigned CLOCK_NS   = 1_000_000_000 / CLOCK_HZ;
	// Accepted line rates in kb/s
	localparam logic [20:0] RATE_HD_KBPS  = 21'd1485000;
	localparam logic [20:0] RATE_HDM_KBPS =
		21'((64'(RATE_HD_KBPS) * 64'd1000) / 64'd1001);
	localparam logic [20:0] RATE_SD_KBPS  = 21'd270000;
	// Host port word layout
	localparam int unsigned HP_WORD    = 16;
	localparam logic [4:0]  HP_LAST    = 5'h0f;
	localparam int unsigned HP_RD_BIT  = 15;
	localparam int unsigned HP_AW      = 12;
	// Register offsets
	localparam logic [11:0] OFF_PROC_DISABLE   = 12'h000;
	localparam logic [11:0] OFF_RX_ERR         = 12'h001;
	localparam logic [11:0] OFF_EDH_ERR        = 12'h003;
	localparam logic [11:0] OFF_DET_FORMAT     = 12'h004;
	localparam logic [11:0] OFF_PAYLOAD_LOW    = 12'h00c;
	localparam logic [11:0] OFF_PAYLOAD_HIGH   = 12'h00d;
	localparam logic [11:0] OFF_RASTER_ONE     = 12'h00e;
	localparam logic [11:0] OFF_RASTER_TWO     = 12'h00f;
	localparam logic [11:0] OFF_RASTER_THREE   = 12'h010;
	localparam logic [11:0] OFF_RASTER_FOUR    = 12'h011;
	// Used bits of the status registers
	localparam logic [15:0] MASK_RX_ERR      = 16'h0fff;
	localparam logic [15:0] MASK_EDH_ERR     = 16'h7fff;
	localparam logic [15:0] MASK_DET_FORMAT  = 16'h7fff;
	localparam logic [15:0] MASK_RASTER_S    = 16'h0fff;
	localparam logic [15:0] MASK_RASTER_L    = 16'h07ff;
	// Processing disable register: a one switches a feature off
	localparam logic [15:0] PROC_DISABLE_RST  = 16'h0000;
	localparam logic [15:0] PROC_DISABLE_MASK = 16'h01ff;
	// Parallel path
	localparam int unsigned WORD_W     = 20;
	localparam int unsigned FIFO_DEPTH = 8;
	typedef enum logic [1:0] {
		HP_IDLE = 2'b00,
		HP_CMD  = 2'b01,
		HP_DATA = 2'b11,
		HP_DONE = 2'b10
	} sdrx_hp_state_t;
endpackage

// >>> tb/sdrx_eq_model.sv
// Cable equalizer model feeding both serial inputs and carrier flags
`timescale 1ns/1ns
module sdrx_eq_model (
	input  wire logic i_clock,
	input  wire logic i_present_one,
	input  wire logic i_present_two,
	input  wire logic i_data_one,
	input  wire logic i_data_two,
	output logic      o_serial_one,
	output logic      o_serial_two,
	output logic      o_cv_n_one,
	output logic      o_cv_n_two
);
	logic noise_q = 1'b0;
	// Without a stream the line chatters, so a stale bit never looks valid
	always @(posedge i_clock) begin
		noise_q <= !noise_q;
	end
	assign o_serial_one = i_present_one ? i_data_one : noise_q;
	assign o_serial_two = i_present_two ? i_data_two : !noise_q;
	assign o_cv_n_one   = !i_present_one;
	assign o_cv_n_two   = !i_present_two;
endmodule // sdrx_eq_model

// >>> tb/tb_sdrx_front.sv
// Self-checking bench of the receiver front-end control block
`timescale 1ns/1ns
module tb_sdrx_front;
	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        m, s, p1, p2, d1, d2, lk, rs, rb, le, hd, dv;
	logic        ser1, ser2, cv1, cv2, car, sb, rsel, mute;
	logic        sclk, cs_n, sdin, sdout, wvalid, wready, ovalid, oready;
	logic        rin, cdet, auto, pns, rso, rsoe, ldat, loe, slew;
	logic [19:0] wdata, odata, w;
	logic [20:0] rate;
	logic [15:0] fen, rd, v;
	logic [15:0] st [9];
	logic [19:0] q [$];
	int          n_errors = 0;
	int          cmp_count = 0;
	localparam logic [11:0] OFFS [9] = '{sdrx_pkg::OFF_RX_ERR,
		sdrx_pkg::OFF_EDH_ERR, sdrx_pkg::OFF_DET_FORMAT,
		sdrx_pkg::OFF_PAYLOAD_LOW, sdrx_pkg::OFF_PAYLOAD_HIGH,
		sdrx_pkg::OFF_RASTER_ONE, sdrx_pkg::OFF_RASTER_TWO,
		sdrx_pkg::OFF_RASTER_THREE, sdrx_pkg::OFF_RASTER_FOUR};
	localparam logic [15:0] MSKS [9] = '{16'h0fff, 16'h7fff, 16'h7fff,
		16'hffff, 16'hffff, 16'h0fff, 16'h0fff, 16'h07ff, 16'h07ff};
	// Reference of the input mux and the loop-through mute
	assign car  = s ? p1 : p2;
	assign sb   = s ? d1 : d2;
	assign rsel = m ? lk : rs;
	assign mute = !car || (rsel && !lk);

	initial begin
		forever #25 i_clock = !i_clock;
	end

	sdrx_eq_model sdrx_eq_model_i (.i_clock(i_clock), .i_present_one(p1),
		.i_present_two(p2), .i_data_one(d1), .i_data_two(d2),
		.o_serial_one(ser1), .o_serial_two(ser2), .o_cv_n_one(cv1),
		.o_cv_n_two(cv2));

	sdrx_front sdrx_front_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_mode_master(m), .i_input_choose(s), .i_serial_in_one(ser1),
		.i_serial_in_two(ser2), .i_carrier_valid_n_one(cv1),
		.i_carrier_valid_n_two(cv2), .o_reclock_in(rin),
		.o_carrier_detect(cdet), .o_auto_detect(auto),
		.o_pass_nonstandard(pns), .i_locked(lk), .i_rate_hd(hd),
		.i_rate_div1001(dv), .i_reclocked_bit(rb), .o_line_rate_kbps(rate),
		.i_loop_enable(le), .i_reclock_sel_in(rs), .o_reclock_sel_out(rso),
		.o_reclock_sel_oe(rsoe), .o_loop_data(ldat), .o_loop_oe(loe),
		.o_loop_hd_slew(slew), .o_feature_enable(fen), .i_rx_err(st[0]),
		.i_edh_err(st[1]), .i_det_format(st[2]), .i_payload_low(st[3]),
		.i_payload_high(st[4]), .i_raster_one(st[5]), .i_raster_two(st[6]),
		.i_raster_three(st[7]), .i_raster_four(st[8]), .i_host_sclk(sclk),
		.i_host_cs_n(cs_n), .i_host_sdin(sdin), .o_host_sdout(sdout),
		.i_word_data(wdata), .i_word_valid(wvalid), .o_word_ready(wready),
		.o_out_data(odata), .o_out_valid(ovalid), .i_out_ready(oready));

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One host frame: 16 command bits, then 16 data bits, MSB first
	task automatic hp(input logic [15:0] cmd, input logic [15:0] wd,
		output logic [15:0] r);
		logic [31:0] f;
		f = {cmd, wd};
		r = '0;
		@(posedge i_clock);
		cs_n <= 1'b0;
		cyc(5);
		for (int i = 0; i < 32; i++) begin
			sdin <= f[31-i];
			cyc(5);
			if (i >= 16) r = {r[14:0], sdout};
			sclk <= 1'b1;
			cyc(5);
			sclk <= 1'b0;
		end
		cyc(5);
		cs_n <= 1'b1;
		cyc(6);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Generous bound: the whole sequence needs about 8300 cycles
	initial begin
		cyc(40000);
		n_errors++;
		conclude();
	end

	initial begin
		{m, s, p1, p2, d1, d2, lk, rs, rb, le, hd, dv} = '0;
		{sclk, sdin, wvalid, oready} = '0;
		cs_n = 1'b1;
		wdata = '0;
		for (int k = 0; k < 9; k++) st[k] = '0;
		void'($urandom(32'ha12d));
		cyc(20);
		i_rst_n <= 1'b1;
		@(negedge i_clock);
		chk(32'(fen), 32'h01ff);
		chk(32'({wready, ovalid}), 32'h2);
		cyc(4);
		repeat (48) begin
			@(posedge i_clock);
			{m, s, p1, p2, d1, d2, lk, rs, rb, le, hd, dv} <= 12'($urandom);
			cyc(6);
			@(negedge i_clock);
			chk(32'({cdet, loe, rso}), 32'({car, le, m && lk}));
			chk(32'(ldat), 32'(!mute && (rsel ? rb : sb)));
			chk(32'({auto, pns, rsoe}), 32'({m, !m, m}));
			if (car) chk(32'(rin), 32'(sb));
			chk(32'(slew), 32'(hd));
			chk(32'(rate), hd ? (dv ? 1485000 * 1000 / 1001 : 1485000)
				: 270000);
		end
		$display("test pins done");
		v = 16'($urandom) & 16'h01ff;
		hp(16'h0000, v, rd);
		chk(32'(fen), 32'(~v & 16'h01ff));
		hp(16'h8000, 16'h0000, rd);
		chk(32'(rd), 32'(v));
		hp({4'h0, OFFS[0]}, 16'hffff, rd);
		chk(32'(fen), 32'(~v & 16'h01ff));
		hp(16'h0000, 16'h0000, rd);
		chk(32'(fen), 32'h01ff);
		for (int k = 0; k < 9; k++) begin
			st[k] <= 16'($urandom);
			cyc(1);
			repeat (2) begin
				hp({4'h8, OFFS[k]}, 16'h0000, rd);
				chk(32'(rd), 32'(st[k] & MSKS[k]));
			end
		end
		hp(16'h8002, 16'h0000, rd);
		chk(32'(rd), 32'h0);
		$display("test host done");
		// Fill with the reader stalled, stream both sides, then drain
		for (int i = 0; i < 8; i++) begin
			w = 20'($urandom);
			wvalid <= 1'b1;
			wdata <= w;
			q.push_back(w);
			cyc(1);
		end
		wvalid <= 1'b0;
		@(negedge i_clock);
		chk(32'({wready, ovalid}), 32'h1);
		for (int n = 0; n < 120; n++) begin
			@(posedge i_clock);
			oready <= (n >= 100) || 1'($urandom);
			wvalid <= (n < 100) && 1'($urandom);
			wdata <= 20'($urandom);
			@(negedge i_clock);
			chk(32'({ovalid, wready}), 32'({q.size() != 0, q.size() != 8}));
			if (ovalid && oready && q.size() > 0)
				chk(32'(odata), 32'(q.pop_front()));
			if (wvalid && wready)
				q.push_back(wdata);
		end
		chk(32'({q.size() == 0, wready, ovalid}), 32'h6);
		$display("test fifo done");
		conclude();
	end
endmodule // tb_sdrx_front
